// ---- tcig_consts.vh ----
// Constants for the channel 2 interrupt-enable gate: offsets, fields, reset values.
// Assumes a 16-bit register port with 4-bit word addresses and one clock.
// Function
// - Enable A bit 1 passes capture/match request of flag B, else blocks it.
// - Enable A bit 0 passes capture/match request of flag A, else blocks it.
// - Enable B bits 15 to 9 always read back as zero.
// - Enable B bit 8 forwards the B-side overflow request only while set.
// - Enable B bit 7 forwards compare request of flag H, else blocks it.
// - Enable B bit 6 forwards compare request of flag G, else blocks it.
// - Enable B bit 5 forwards compare request of flag F, else blocks it.
// - Enable B bit 4 forwards compare request of flag E, else blocks it.
// - Enable B bit 3 forwards compare request of flag D, else blocks it.
// - Enable B bit 2 forwards compare request of flag C, else blocks it.
// - Enable B bit 1 forwards compare request of flag B, else blocks it.
// - Enable B bit 0 forwards compare request of flag A, else blocks it.
// - All enable bits reset to zero, so every request starts disabled.
`ifndef TCIG_CONSTS_VH
`define TCIG_CONSTS_VH

// Register port geometry
`define TCIG_ADDR_W 4
`define TCIG_DATA_W 16

// Word addresses
`define TCIG_ADR_EN_A 4'h0
`define TCIG_ADR_EN_B 4'h1
`define TCIG_ADR_EVT_STAT 4'h2
`define TCIG_ADR_EVT_CLR 4'h3
`define TCIG_ADR_EVT_EN 4'h4

// Enable register A fields handled here
`define TCIG_A_W 2
`define TCIG_A_MSB 1
`define TCIG_A_RESET 2'h0
`define TCIG_A_RSV_ZERO 14'h0000

// Enable register B fields
`define TCIG_B_W 9
`define TCIG_B_MSB 8
`define TCIG_B_OVF_BIT 8
`define TCIG_B_CMP_MSB 7
`define TCIG_B_RSV_LSB 9
`define TCIG_B_RESET 9'h000
`define TCIG_B_RSV_ZERO 7'h00

// Event status layout
`define TCIG_EVT_W 12
`define TCIG_EVT_MSB 11
`define TCIG_EVT_CAP_LSB 0
`define TCIG_EVT_CMP_LSB 2
`define TCIG_EVT_OVF_BIT 10
`define TCIG_EVT_RSVWR_BIT 11
`define TCIG_EVT_RESET 12'h000
`define TCIG_EVT_PAD_ZERO 4'h0

`define TCIG_ZERO16 16'h0000

`endif

// ---- tcig_gate.v ----
// Registered request gate: each request is its flag AND its enable.
// Assumes flags are levels synchronous to the clock.
`timescale 1ns/1ps
module tcig_gate #(
  parameter W = 1
) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Flags and enables
  input wire [W-1:0] flag,
  input wire [W-1:0] en,
  // Gated requests
  output reg [W-1:0] req_r,
  output wire [W-1:0] req_nxt
);

  // Gate is combinational, the output one clock behind to keep it glitch free
  assign req_nxt = flag & en;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      req_r <= {W{1'b0}};
    end else begin
      req_r <= req_nxt;
    end
  end

endmodule

// ---- tcig_evt.v ----
// Sticky event status with write-one-to-clear and a masked level interrupt.
// Assumes events are one-cycle pulses from the same clock.
`timescale 1ns/1ps
`include "tcig_consts.vh"
module tcig_evt (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Events and software controls
  input wire [`TCIG_EVT_MSB:0] evt,
  input wire [`TCIG_EVT_MSB:0] clr,
  input wire [`TCIG_EVT_MSB:0] mask,
  // State
  output reg [`TCIG_EVT_MSB:0] stat_r,
  output reg irq_r
);

  reg [`TCIG_EVT_MSB:0] stat_nxt;

  // Set beats clear so an event landing on a clear is not lost
  always @* begin
    stat_nxt = (stat_r & ~clr) | evt;
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stat_r <= `TCIG_EVT_RESET;
      irq_r <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      irq_r <= |(stat_nxt & mask);
    end
  end

endmodule

// ---- tcig_top.v ----
// Channel 2 interrupt-enable gate: enable registers A (low bits) and B,
// gated request outputs, and a sticky event summary with one interrupt line.
// Assumes status flags are levels synchronous to CORE_CLK and a single-cycle
// strobe master that never asserts both strobes together.
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "tcig_consts.vh"
module tcig_top (
  // Clock and reset
  input wire CORE_CLK,
  input wire RST_B,
  // Register port
  input wire [`TCIG_ADDR_W-1:0] REG_ADDR,
  input wire [`TCIG_DATA_W-1:0] REG_WDATA,
  input wire REG_WR,
  input wire REG_RD,
  output reg [`TCIG_DATA_W-1:0] REG_RDATA,
  // Status flags from the channel 2 counters
  input wire [`TCIG_A_MSB:0] CAPTURE_MATCH_FLAG,
  input wire [`TCIG_B_CMP_MSB:0] CMP_FLAG,
  input wire OVERFLOW_FLAG_B,
  // Gated requests to the interrupt controller
  output wire [`TCIG_A_MSB:0] CAPTURE_MATCH_IRQ,
  output wire [`TCIG_B_CMP_MSB:0] CMP_IRQ,
  output wire OVERFLOW_IRQ_B,
  // Summary interrupt
  output wire IRQ_OUT
);

  // Register storage
  reg [`TCIG_A_MSB:0] en_a_r;
  reg [`TCIG_A_MSB:0] en_a_nxt;
  reg [`TCIG_B_MSB:0] en_b_r;
  reg [`TCIG_B_MSB:0] en_b_nxt;
  reg [`TCIG_EVT_MSB:0] evt_en_r;
  reg [`TCIG_EVT_MSB:0] evt_en_nxt;
  reg [`TCIG_EVT_MSB:0] evt_clr;
  reg [`TCIG_DATA_W-1:0] rdata_nxt;
  reg rsv_wr_evt;

  wire [`TCIG_A_MSB:0] cap_req_r;
  wire [`TCIG_A_MSB:0] cap_req_nxt;
  wire [`TCIG_B_MSB:0] b_req_r;
  wire [`TCIG_B_MSB:0] b_req_nxt;
  wire [`TCIG_B_MSB:0] b_flags;
  wire [`TCIG_EVT_MSB:0] evt_stat;
  wire [`TCIG_EVT_MSB:0] evt_pulse;
  wire irq_sum;

  // Zero-extends a narrow field onto the data bus
  function [`TCIG_DATA_W-1:0] f_ext;
    input [`TCIG_DATA_W-1:0] v;
    begin
      f_ext = v;
    end
  endfunction

  // True for a write strobe at the given address
  function f_wr_hit;
    input wr;
    input [`TCIG_ADDR_W-1:0] addr;
    input [`TCIG_ADDR_W-1:0] target;
    begin
      f_wr_hit = wr && (addr == target);
    end
  endfunction

  // Write path
  always @* begin
    en_a_nxt = en_a_r;
    en_b_nxt = en_b_r;
    evt_en_nxt = evt_en_r;
    evt_clr = `TCIG_EVT_RESET;
    rsv_wr_evt = 1'b0;
    if (f_wr_hit(REG_WR, REG_ADDR, `TCIG_ADR_EN_A)) begin
      // Upper bits of register A belong to other logic and are dropped here
      en_a_nxt = REG_WDATA[`TCIG_A_MSB:0];
    end
    if (f_wr_hit(REG_WR, REG_ADDR, `TCIG_ADR_EN_B)) begin
      en_b_nxt = REG_WDATA[`TCIG_B_MSB:0];
      // Reserved bits are never stored; a nonzero write is flagged as misuse
      rsv_wr_evt = |REG_WDATA[`TCIG_DATA_W-1:`TCIG_B_RSV_LSB];
    end
    if (f_wr_hit(REG_WR, REG_ADDR, `TCIG_ADR_EVT_EN)) begin
      evt_en_nxt = REG_WDATA[`TCIG_EVT_MSB:0];
    end
    if (f_wr_hit(REG_WR, REG_ADDR, `TCIG_ADR_EVT_CLR)) begin
      evt_clr = REG_WDATA[`TCIG_EVT_MSB:0];
    end
  end

  // Read path; unmapped and write-only addresses read zero
  always @* begin
    rdata_nxt = `TCIG_ZERO16;
    if (REG_RD) begin
      case (REG_ADDR)
        `TCIG_ADR_EN_A: begin
          rdata_nxt = f_ext({`TCIG_A_RSV_ZERO, en_a_r});
        end
        `TCIG_ADR_EN_B: begin
          rdata_nxt = f_ext({`TCIG_B_RSV_ZERO, en_b_r});
        end
        `TCIG_ADR_EVT_STAT: begin
          rdata_nxt = f_ext({`TCIG_EVT_PAD_ZERO, evt_stat});
        end
        `TCIG_ADR_EVT_EN: begin
          rdata_nxt = f_ext({`TCIG_EVT_PAD_ZERO, evt_en_r});
        end
        default: begin
          rdata_nxt = `TCIG_ZERO16;
        end
      endcase
    end
  end

  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      en_a_r <= `TCIG_A_RESET;
      en_b_r <= `TCIG_B_RESET;
      evt_en_r <= `TCIG_EVT_RESET;
      REG_RDATA <= `TCIG_ZERO16;
    end else begin
      en_a_r <= en_a_nxt;
      en_b_r <= en_b_nxt;
      evt_en_r <= evt_en_nxt;
      REG_RDATA <= rdata_nxt;
    end
  end

  // Capture/compare-match gating from register A
  tcig_gate #(.W(`TCIG_A_W)) u_gate_a (
    .clk(CORE_CLK),
    .rst_b(RST_B),
    .flag(CAPTURE_MATCH_FLAG),
    .en(en_a_r),
    .req_r(cap_req_r),
    .req_nxt(cap_req_nxt)
  );

  // Overflow sits above the eight compare flags, as in register B
  assign b_flags = {OVERFLOW_FLAG_B, CMP_FLAG};

  tcig_gate #(.W(`TCIG_B_W)) u_gate_b (
    .clk(CORE_CLK),
    .rst_b(RST_B),
    .flag(b_flags),
    .en(en_b_r),
    .req_r(b_req_r),
    .req_nxt(b_req_nxt)
  );

  assign CAPTURE_MATCH_IRQ = cap_req_r;
  assign CMP_IRQ = b_req_r[`TCIG_B_CMP_MSB:0];
  assign OVERFLOW_IRQ_B = b_req_r[`TCIG_B_OVF_BIT];

  // Events 10:0 are rising edges of the gated requests, so a held flag counts once; bit 11 is the reserved write
  assign evt_pulse = {rsv_wr_evt,
                      b_req_nxt & ~b_req_r,
                      cap_req_nxt & ~cap_req_r};

  tcig_evt u_evt (
    .clk(CORE_CLK),
    .rst_b(RST_B),
    .evt(evt_pulse),
    .clr(evt_clr),
    .mask(evt_en_r),
    .stat_r(evt_stat),
    .irq_r(irq_sum)
  );

  assign IRQ_OUT = irq_sum;

endmodule

// ---- tcig_monitor.sv ----
// Checker for tcig_top: enable readback, gated requests, read data timing.
// Assumes the enables change only through bus writes.
`timescale 1ns/1ps
module tcig_monitor (
  // Clock and reset
  input wire CORE_CLK,
  input wire RST_B,
  // Register port
  input wire [3:0] REG_ADDR,
  input wire [15:0] REG_WDATA,
  input wire REG_WR,
  input wire REG_RD,
  input wire [15:0] REG_RDATA,
  // Flags and requests
  input wire [1:0] CAPTURE_MATCH_FLAG,
  input wire [7:0] CMP_FLAG,
  input wire OVERFLOW_FLAG_B,
  input wire [1:0] CAPTURE_MATCH_IRQ,
  input wire [7:0] CMP_IRQ,
  input wire OVERFLOW_IRQ_B,
  input wire IRQ_OUT
);
  reg [1:0] en_a_r;
  reg [8:0] en_b_r;
  wire [1:0] cap_g = CAPTURE_MATCH_FLAG & en_a_r;
  wire [7:0] cmp_g = CMP_FLAG & en_b_r[7:0];
  wire ovf_g = OVERFLOW_FLAG_B & en_b_r[8];
  // Shadow enables; a reserved write to B keeps only bits 8:0
  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      en_a_r <= 2'h0;
      en_b_r <= 9'h000;
    end else if (REG_WR && REG_ADDR == 4'h0) begin
      en_a_r <= REG_WDATA[1:0];
    end else if (REG_WR && REG_ADDR == 4'h1) begin
      en_b_r <= REG_WDATA[8:0];
    end
  end
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  sequence s_arm_b0;
    REG_WR && REG_ADDR == 4'h1 && REG_WDATA[0];
  endsequence
  sequence s_flag_b0;
    CMP_FLAG[0] [*2];
  endsequence
  AST_RDATA_IDLE: assert property (!$past(REG_RD) |-> REG_RDATA == 16'h0000)
    else $error("read data outside its cycle");
  AST_READ_A: assert property ($past(REG_RD) && $past(REG_ADDR) == 4'h0 |->
    REG_RDATA == {14'h0000, $past(en_a_r)}) else $error("enable A readback");
  AST_READ_B: assert property ($past(REG_RD) && $past(REG_ADDR) == 4'h1 |->
    REG_RDATA == {7'h00, $past(en_b_r)}) else $error("enable B readback");
  AST_HI_ZERO: assert property (REG_RDATA[15:12] == 4'h0) else $error("high read bits");
  AST_CAP_GATE: assert property (CAPTURE_MATCH_IRQ == $past(cap_g))
    else $error("capture request gate");
  AST_CMP_GATE: assert property (CMP_IRQ == $past(cmp_g))
    else $error("compare request gate");
  AST_OVF_GATE: assert property (OVERFLOW_IRQ_B == $past(ovf_g))
    else $error("overflow request gate");
  AST_ARM_FIRE: assert property (s_arm_b0 ##1 s_flag_b0 |-> CMP_IRQ[0])
    else $error("compare A request missing");
endmodule
bind tcig_top tcig_monitor u_mon (.CORE_CLK, .RST_B, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD,
  .REG_RDATA, .CAPTURE_MATCH_FLAG, .CMP_FLAG, .OVERFLOW_FLAG_B, .CAPTURE_MATCH_IRQ,
  .CMP_IRQ, .OVERFLOW_IRQ_B, .IRQ_OUT);

// ---- tcig_flag_src.sv ----
// Status flag source standing in for the channel 2 counters.
// Assumes one clock; flags are levels that move only at rising edges.
`timescale 1ns/1ps
module tcig_flag_src (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Pattern in, flags out: bit 10 overflow, 9:2 compare, 1:0 capture
  input wire [10:0] want,
  output reg [10:0] flg
);
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flg <= 11'h000;
    end else begin
      flg <= want;
    end
  end
endmodule

// ---- tcig_top_bench.sv ----
// Bench for tcig_top: enable walk, reserved write, event interrupt.
// Assumes tcig_flag_src drives the status flags.
`timescale 1ns/1ps
module tcig_top_bench;
  reg CORE_CLK = 0;
  reg RST_B = 0;
  reg [3:0] REG_ADDR = 4'h0;
  reg [15:0] REG_WDATA = 16'h0000;
  reg REG_WR = 0;
  reg REG_RD = 0;
  reg [10:0] want = 11'h000;
  reg [10:0] e;
  wire [10:0] flg;
  wire [10:0] irq;
  wire [15:0] REG_RDATA;
  wire IRQ_OUT;
  integer err_total = 0;
  integer checks_done = 0;
  integer i;
  initial forever #50 CORE_CLK = ~CORE_CLK;
  tcig_flag_src src (.clk(CORE_CLK), .rst_b(RST_B), .want(want), .flg(flg));
  tcig_top dut (.CORE_CLK, .RST_B, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA,
    .CAPTURE_MATCH_FLAG(flg[1:0]), .CMP_FLAG(flg[9:2]), .OVERFLOW_FLAG_B(flg[10]),
    .CAPTURE_MATCH_IRQ(irq[1:0]), .CMP_IRQ(irq[9:2]), .OVERFLOW_IRQ_B(irq[10]), .IRQ_OUT);
  task chk(input string n, input [15:0] s, input [15:0] x);
    checks_done = checks_done + 1;
    if (s !== x) begin
      err_total = err_total + 1;
      $display("MISMATCH %s expected %h seen %h", n, x, s);
    end
  endtask
  task tick;
    @(posedge CORE_CLK);
    @(negedge CORE_CLK);
  endtask
  task wr(input [3:0] a, input [15:0] d);
    @(posedge CORE_CLK);
    REG_WR <= 1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CORE_CLK);
    REG_WR <= 0;
  endtask
  task rd(input [3:0] a, input [15:0] x);
    @(posedge CORE_CLK);
    REG_RD <= 1;
    REG_ADDR <= a;
    @(posedge CORE_CLK);
    REG_RD <= 0;
    @(negedge CORE_CLK);
    chk("rdata", REG_RDATA, x);
  endtask
  task conclude;
    if (err_total == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #300000;
    err_total = err_total + 1;
    conclude;
  end
  initial begin
    repeat (5) @(posedge CORE_CLK);
    RST_B <= 1;
    rd(4'h0, 16'h0000);
    rd(4'h1, 16'h0000);
    @(posedge CORE_CLK);
    want <= 11'h7FF;
    // Flags stay up while one enable at a time walks across both registers
    for (i = 0; i < 11; i = i + 1) begin
      e = 11'h001 << i;
      wr(4'h0, {14'h0000, e[1:0]});
      wr(4'h1, {7'h00, e[10:2]});
      tick;
      chk("irq", irq, e);
    end
    @(posedge CORE_CLK);
    want <= 11'h000;
    repeat (2) @(posedge CORE_CLK);
    @(negedge CORE_CLK);
    chk("irq drop", irq, 16'h0000);
    wr(4'h1, 16'hFE00);
    rd(4'h1, 16'h0000);
    rd(4'h2, 16'h0FFF);
    chk("irq masked", IRQ_OUT, 16'h0000);
    wr(4'h4, 16'h0800);
    tick;
    chk("irq on", IRQ_OUT, 16'h0001);
    wr(4'h3, 16'h0FFF);
    tick;
    chk("irq off", IRQ_OUT, 16'h0000);
    rd(4'h2, 16'h0000);
    rd(4'h3, 16'h0000);
    rd(4'hF, 16'h0000);
    // Mid-run reset with every A and B enable set: all must come back cleared
    wr(4'h0, 16'h0003);
    wr(4'h1, 16'h01FF);
    @(posedge CORE_CLK);
    RST_B <= 0;
    want <= 11'h7FF;
    @(posedge CORE_CLK);
    RST_B <= 1;
    rd(4'h0, 16'h0000);
    rd(4'h1, 16'h0000);
    chk("irq after reset", irq, 16'h0000);
    chk("irq out after reset", IRQ_OUT, 16'h0000);
    rd(4'h2, 16'h0000);
    conclude;
  end
endmodule
